// [verilog/ecc_log_pkg.sv]
// Package with constants and types for the wide memory ECC and error log block.
package ecc_log_pkg;
    localparam int HALF_W = 64;
    localparam int CHK_W = 8;
    localparam int CODE_W = 72;
    localparam int LOG_DEPTH = 16;
    localparam int LOG_AW = 4;
    localparam int BOARD_W = 4;
    localparam int ADDR_W = 24;
    localparam int ROWADR_W = 10;
    localparam int WORD_BYTES = 16;
    localparam int PWRUP_CYCLES = 64;
    localparam logic [4:0] WB_REG_CTRL = 5'h00;
    localparam logic [4:0] WB_REG_STAT = 5'h04;
    localparam logic [4:0] WB_REG_DISP = 5'h08;
    localparam logic [4:0] WB_REG_CNT = 5'h0C;
    localparam logic [4:0] WB_REG_ADDR = 5'h10;
    localparam logic [4:0] WB_REG_MODE = 5'h14;
    localparam logic [4:0] WB_REG_WDAT = 5'h18;
    localparam logic [4:0] WB_REG_RDAT = 5'h1C;
    localparam logic [31:0] WB_UNMAPPED = 32'h00000000;
    localparam logic [2:0] MODE_WW_READ = 3'h0;
    localparam logic [2:0] MODE_WW_WRITE = 3'h1;
    localparam logic [2:0] MODE_BYTE_WRITE = 3'h2;
    localparam logic [2:0] MODE_RMW_BYTE = 3'h3;
    localparam logic [2:0] MODE_RMW_WORD = 3'h4;
    localparam logic [3:0] MAX_WRITE_BYTES = 4'h9;

    typedef struct packed {
        logic [3:0] board;
        logic row;
        logic [6:0] bitPos;
        logic word;
    } logEntry_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [2:0] mode;
        logic [15:0] byteSel;
        logic [127:0] mask;
        logic [127:0] data;
    } memReq_s;
endpackage

// [verilog/wide_memory_ecc_error_log.sv]
// Wide memory with per-half SEC-DED check codes, a 16-entry error log and front-panel controls.
// Functional notes
// - Each 64-bit half stores its own 8-bit code.
// - Reads recompute and compare code per half.
// - Single-bit error per half is corrected automatically.
// - Multi-bit error per half flagged, not corrected.
// - Detected error builds chip-locating log message.
// - Log holds sixteen entries, each displayable.
// - Clear control erases all log entries.
// - Power-up sequence erases the log.
// - Begin resets display pointer, keeps entries.
// - Error lamp stays on until log cleared.
// - Entry shown only while examine is held.
// - Sixteen errors light full lamp, stop recording.
// - Entry shows board, row, bit, word digits.
// - Board field matches four board-select lines.
// - Row field is electrical row 0 or 1.
// - Bit 0-79 then half digit, 000-791.
// - Each half has its own data bus.
// - Address maps to row, column, board enables.
// - Ready lamp lights after power-up completes.
// - Whole-word read/write, always all 16 bytes.
// - Byte write stores one to nine bytes.
// - Byte read-modify-write changes selected bytes.
// - Word read-modify-write changes all bits or none, set by one mask bit.
`timescale 1ns/1ps
`default_nettype none
module wide_memory_ecc_error_log #(
    parameter int MEM_AW = 6
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic logClear,
    input wire logic logBegin,
    input wire logic logExamine,
    input wire logic [ecc_log_pkg::CODE_W-1:0] faultInjectLo,
    input wire logic [ecc_log_pkg::CODE_W-1:0] faultInjectHi,
    output logic [79:0] lowerHalfDataBus,
    output logic [79:0] upperHalfDataBus,
    output logic [ecc_log_pkg::BOARD_W-1:0] arrayBoardSelect,
    output logic [19:0] arrayAddressLines,
    output logic logFullLamp,
    output logic errorLamp,
    output logic readyLamp,
    output logic displayOn,
    output ecc_log_pkg::logEntry_s displayEntry
);
    import ecc_log_pkg::*;

    // One-hot transfer sequencer: power-up, idle, read, write and done.
    typedef enum logic [4:0] {
        ST_PWRUP = 5'b00001,
        ST_IDLE = 5'b00010,
        ST_READ = 5'b00100,
        ST_WRITE = 5'b01000,
        ST_DONE = 5'b10000
    } state_e;

    // Hamming position of data bit i inside a 72-bit SEC-DED code word (position 0 is overall parity).
    function automatic logic [6:0] dataPos(input int i);
        int p;
        int k;
        p = 0;
        k = -1;
        for (int j = 1; j < 72; j++) begin
            if ((j & (j - 1)) != 0 && k < i) begin
                k = k + 1;
                p = j;
            end
        end
        return 7'(p);
    endfunction

    // Builds the 72-bit stored code word for one 64-bit half.
    function automatic logic [CODE_W-1:0] encode(input logic [HALF_W-1:0] d);
        logic [CODE_W-1:0] cw;
        cw = '0;
        for (int i = 0; i < HALF_W; i++) begin
            cw[dataPos(i)] = d[i];
        end
        // Check bits sit at the power-of-two positions; each covers the positions that have its bit set.
        for (int b = 0; b < 7; b++) begin
            logic par;
            par = 1'b0;
            for (int j = 1; j < CODE_W; j++) begin
                if (j[b]) begin
                    par = par ^ cw[j];
                end
            end
            cw[1 << b] = par;
        end
        cw[0] = ^cw[CODE_W-1:1];
        return cw;
    endfunction

    // Syndrome and overall parity check for a retrieved code word.
    function automatic logic [7:0] syndrome(input logic [CODE_W-1:0] cw);
        logic [6:0] s;
        s = '0;
        for (int j = 1; j < CODE_W; j++) begin
            if (cw[j]) begin
                s = s ^ 7'(j);
            end
        end
        return {^cw, s};
    endfunction

    // Pulls the 64 data bits back out of a corrected code word.
    function automatic logic [HALF_W-1:0] extract(input logic [CODE_W-1:0] cw);
        logic [HALF_W-1:0] d;
        for (int i = 0; i < HALF_W; i++) begin
            d[i] = cw[dataPos(i)];
        end
        return d;
    endfunction

    // Expands a byte select into a 128-bit write mask.
    function automatic logic [127:0] byteMask(input logic [15:0] sel);
        logic [127:0] m;
        for (int i = 0; i < WORD_BYTES; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // Two code words per location, one per half; storage is behind the check codes.
    logic [CODE_W-1:0] memLo [0:(1<<MEM_AW)-1];
    logic [CODE_W-1:0] memHi [0:(1<<MEM_AW)-1];
    logEntry_s logMem [0:LOG_DEPTH-1];

    state_e state_r, state_nxt;
    memReq_s req_r;
    logic [127:0] rdData_r;
    logic [1:0] uncorr_r;
    // One bit wider than the log index so that a full log of sixteen differs from an empty one.
    logic [LOG_AW:0] logCount_r;
    logic [LOG_AW-1:0] dispPtr_r;
    logic [6:0] pwrCnt_r;
    // Resets low, the idle level of the switch, so examine held through reset counts as a press when reset ends.
    logic examPrev_r;
    logic go_r;
    logic wbAck_r;
    logic [31:0] wbDat_r;
    logic [CODE_W-1:0] rawLo_r, rawHi_r;

    wire wbReq = wb_cyc_i && wb_stb_i && !wbAck_r;
    wire wbWr = wbReq && wb_we_i;
    wire [4:0] wbOff = wb_adr_i[4:0];
    wire wbHit = (wb_adr_i[31:5] == 27'h0);
    wire [MEM_AW-1:0] memIdx = req_r.addr[MEM_AW-1:0];
    // One decoded write enable per register keeps the bus process short.
    wire wrCtrl = wbWr && wbHit && (wbOff == WB_REG_CTRL) && wb_sel_i[0];
    wire wrAddr = wbWr && wbHit && (wbOff == WB_REG_ADDR);
    wire wrMode = wbWr && wbHit && (wbOff == WB_REG_MODE);
    wire wrWdat = wbWr && wbHit && (wbOff == WB_REG_WDAT);
    wire wbRd = wbReq && !wb_we_i;
    // A transfer starts in the one idle cycle in which the start request is seen.
    wire startXfer = (state_r == ST_IDLE) && go_r;

    // Read path: raw codes plus injected faults from the test interface.
    wire [CODE_W-1:0] cwLo = rawLo_r ^ faultInjectLo;
    wire [CODE_W-1:0] cwHi = rawHi_r ^ faultInjectHi;
    wire [7:0] synLo = syndrome(cwLo);
    wire [7:0] synHi = syndrome(cwHi);
    // Odd overall parity means one bit flipped; even parity with nonzero syndrome means two or more.
    wire sglLo = synLo[7];
    wire sglHi = synHi[7];
    wire dblLo = !synLo[7] && (synLo[6:0] != 7'h0);
    wire dblHi = !synHi[7] && (synHi[6:0] != 7'h0);
    // A double error leaves the word as read; its data is not trusted and the status bits say so.
    wire [CODE_W-1:0] fixLo = sglLo ? (cwLo ^ (72'h1 << synLo[6:0])) : cwLo;
    wire [CODE_W-1:0] fixHi = sglHi ? (cwHi ^ (72'h1 << synHi[6:0])) : cwHi;
    wire [127:0] corrData = {extract(fixHi), extract(fixLo)};
    wire errLo = sglLo || dblLo;
    wire errHi = sglHi || dblHi;

    // Locates the failing bit as a bus bit position 0-79 within the half that failed.
    wire [6:0] failBit = errLo ? synLo[6:0] : synHi[6:0];
    wire [6:0] busBit = (failBit == 7'h0) ? 7'h0 : 7'(failBit - 7'h1);
    // The board and row digits come from the address of the failing read.
    logEntry_s newEntry;
    assign newEntry.board = req_r.addr[ADDR_W-1 -: BOARD_W];
    assign newEntry.row = req_r.addr[ADDR_W-BOARD_W-1];
    assign newEntry.bitPos = busBit;
    assign newEntry.word = !errLo;
    wire logEvent = (state_r == ST_READ) && (errLo || errHi);
    wire logFull = logCount_r[LOG_AW];
    // Lamps follow the count, so a clear darkens them within two cycles.
    wire errLampNxt = (logCount_r != '0) && !logClear;
    wire fullLampNxt = logFull && !logClear;
    wire examPress = logExamine && !examPrev_r;
    // Syndrome digits on the data buses stay zero for a clean half.
    wire [7:0] synFieldLo = (synLo[6:0] == 7'h0) ? 8'h0 : synLo;
    wire [7:0] synFieldHi = (synHi[6:0] == 7'h0) ? 8'h0 : synHi;

    // Byte write is limited to nine selected bytes; a selection of more is replaced by the nine lowest bytes.
    wire [15:0] bwSel;
    assign bwSel = (($countones(req_r.byteSel) > 9) ? 16'h01FF : req_r.byteSel);
    logic [127:0] mergeMask;
    always_comb begin
        case (req_r.mode)
            MODE_WW_WRITE: mergeMask = {128{1'b1}};
            MODE_BYTE_WRITE: mergeMask = byteMask(bwSel);
            MODE_RMW_BYTE: mergeMask = byteMask(req_r.byteSel);
            MODE_RMW_WORD: mergeMask = req_r.mask;
            default: mergeMask = '0;
        endcase
    end
    // Only a whole-word write starts from zero; every other store keeps the bytes it does not select,
    // which is why byte write reads the location first.
    wire wholeWrite = (req_r.mode == MODE_WW_WRITE);
    wire [127:0] baseData = wholeWrite ? 128'h0 : rdData_r;
    wire [127:0] newData = (baseData & ~mergeMask) | (req_r.data & mergeMask);
    wire needRead = (req_r.mode != MODE_WW_WRITE);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_PWRUP: state_nxt = (pwrCnt_r == 7'(PWRUP_CYCLES)) ? ST_IDLE : ST_PWRUP;
            ST_IDLE: state_nxt = go_r ? (needRead ? ST_READ : ST_WRITE) : ST_IDLE;
            ST_READ: state_nxt = (req_r.mode == MODE_WW_READ) ? ST_DONE : ST_WRITE;
            ST_WRITE: state_nxt = ST_DONE;
            ST_DONE: state_nxt = ST_IDLE;
            default: state_nxt = ST_PWRUP;
        endcase
    end

    // The power-up counter runs once after reset; the log is held clear until it ends.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= ST_PWRUP;
            pwrCnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_PWRUP) begin
                pwrCnt_r <= pwrCnt_r + 7'd1;
            end
        end
    end

    // Memory core: every store recomputes both half codes from the merged data.
    always_ff @(posedge mclk) begin
        rawLo_r <= memLo[memIdx];
        rawHi_r <= memHi[memIdx];
        if (state_r == ST_WRITE) begin
            memLo[memIdx] <= encode(newData[63:0]);
            memHi[memIdx] <= encode(newData[127:64]);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdData_r <= '0;
            uncorr_r <= '0;
            lowerHalfDataBus <= '0;
            upperHalfDataBus <= '0;
            arrayBoardSelect <= '0;
            arrayAddressLines <= '0;
        end else begin
            // Address lines load once per transfer so they stand steady while the array is busy.
            if (startXfer) begin
                arrayBoardSelect <= req_r.addr[ADDR_W-1 -: BOARD_W];
                arrayAddressLines <= req_r.addr[19:0];
            end
            if (state_r == ST_READ) begin
                rdData_r <= corrData;
                uncorr_r <= {dblHi, dblLo};
                lowerHalfDataBus <= {8'h0, synFieldLo, corrData[63:0]};
                upperHalfDataBus <= {8'h0, synFieldHi, corrData[127:64]};
            end
        end
    end

    // Error log: clear and power-up erase it; writes stop once sixteen are held.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            logCount_r <= '0;
            dispPtr_r <= '0;
            examPrev_r <= 1'b0;
            displayOn <= 1'b0;
            displayEntry <= '0;
            errorLamp <= 1'b0;
            logFullLamp <= 1'b0;
            readyLamp <= 1'b0;
        end else begin
            examPrev_r <= logExamine;
            readyLamp <= (state_r != ST_PWRUP);
            if (logClear || state_r == ST_PWRUP) begin
                logCount_r <= '0;
                dispPtr_r <= '0;
            end else if (logEvent && !logFull) begin
                logMem[logCount_r[LOG_AW-1:0]] <= newEntry;
                logCount_r <= logCount_r + 5'h1;
            end
            // Begin wins over examine unless clear is also high; then a press in the same cycle still advances the pointer.
            if (logBegin && !logClear) begin
                dispPtr_r <= '0;
            end else if (examPress) begin
                displayEntry <= logMem[dispPtr_r];
                dispPtr_r <= dispPtr_r + 4'd1;
            end
            displayOn <= logExamine;
            errorLamp <= errLampNxt;
            logFullLamp <= fullLampNxt;
        end
    end

    // Read data selection; an unmapped offset or an address outside the window reads as zero.
    logic [31:0] rdMux;
    always_comb begin
        rdMux = WB_UNMAPPED;
        if (wbHit) begin
            case (wbOff)
                WB_REG_STAT: rdMux = {22'h0, uncorr_r, readyLamp, errorLamp, logFullLamp, go_r,
                    state_r == ST_IDLE, displayOn, 2'h0};
                WB_REG_DISP: rdMux = {19'h0, displayEntry};
                WB_REG_CNT: rdMux = {23'h0, dispPtr_r, logCount_r};
                WB_REG_ADDR: rdMux = {8'h0, req_r.addr};
                WB_REG_RDAT: rdMux = rdData_r[31:0];
                default: rdMux = WB_UNMAPPED;
            endcase
        end
    end

    // Wishbone slave: one-cycle ack; a write of bit 0 to the control register launches a transfer.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wbAck_r <= 1'b0;
            wbDat_r <= '0;
            go_r <= 1'b0;
            req_r <= '0;
        end else begin
            // The ack is one cycle wide because a request is refused while the previous ack stands.
            wbAck_r <= wbReq;
            if (startXfer) begin
                go_r <= 1'b0;
            end
            // A start request during power-up is dropped, as no stored word can be trusted yet.
            if (wrCtrl) begin
                go_r <= wb_dat_i[0] && state_r != ST_PWRUP;
            end
            if (wrAddr) begin
                req_r.addr <= wb_dat_i[ADDR_W-1:0];
            end
            if (wrMode) begin
                req_r.mode <= wb_dat_i[2:0];
                req_r.byteSel <= wb_dat_i[31:16];
                req_r.mask <= {128{wb_dat_i[3]}};
            end
            // Write data shifts in 32 bits at a time; the last of four writes supplies bits 31:0.
            if (wrWdat) begin
                req_r.data <= {req_r.data[95:0], wb_dat_i};
            end
            if (wbRd) begin
                wbDat_r <= rdMux;
            end
        end
    end

    assign wb_ack_o = wbAck_r;
    assign wb_dat_o = wbDat_r;
endmodule
`default_nettype wire

// [test/wide_memory_ecc_error_log_asserts.sv]
// Checker for bus answer timing, panel lamps and display of the ECC log block.
`timescale 1ns/1ps
`default_nettype none
module wide_memory_ecc_error_log_asserts #(
    parameter int MEM_AW = 6
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic logClear,
    input wire logic logExamine,
    input wire logic logFullLamp,
    input wire logic errorLamp,
    input wire logic readyLamp,
    input wire logic displayOn
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in the next cycle");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge longer than one cycle");
    err_sticky_a: assert property ((!logClear)[*3] ##0 errorLamp |=> errorLamp)
        else $error("error lamp went dark without a clear");
    clear_lamps_a: assert property (logClear |-> ##2 (!errorLamp && !logFullLamp))
        else $error("lamps still lit after a log clear");
    full_err_a: assert property (logFullLamp |-> errorLamp)
        else $error("full lamp lit without error lamp");
    ready_stay_a: assert property (readyLamp |=> readyLamp)
        else $error("ready lamp dropped while running");
    powerup_dark_a: assert property ($rose(rst_n) |-> (!readyLamp && !errorLamp)[*8])
        else $error("lamp lit early in the power-up sequence");
    display_off_a: assert property ((!logExamine)[*2] |-> !displayOn)
        else $error("display lit without examine held");
    examine_show_a: assert property ($rose(logExamine) && errorLamp |-> ##[1:3] displayOn)
        else $error("examine did not light the display");
    cover property (logFullLamp);
    cover property (displayOn && errorLamp);
    cover property (wb_ack_o && wb_we_i);
endmodule
bind wide_memory_ecc_error_log wide_memory_ecc_error_log_asserts #(.MEM_AW(MEM_AW)) u_chk (.*);
`default_nettype wire

// [test/host_board_model.sv]
// Host board model issuing classic single Wishbone cycles to the memory block.
`timescale 1ns/1ps
`default_nettype none
module host_board_model (
    input wire logic mclk,
    input wire logic wbAck,
    input wire logic [31:0] wbDatR,
    output logic [31:0] wbAdr,
    output logic [31:0] wbDatW,
    output logic [3:0] wbSel,
    output logic wbWe,
    output logic wbCyc,
    output logic wbStb
);
    initial begin
        {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatW} = 71'h0;
    end
    // Released address and data lines show the inverse of their last value so stale data cannot pass as a match.
    task automatic access(input logic we, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        {wbCyc, wbStb, wbWe, wbSel} <= {2'h3, we, 4'hF};
        wbAdr <= a;
        wbDatW <= d;
        do @(posedge mclk); while (wbAck !== 1'b1);
        q = wbDatR;
        {wbCyc, wbStb, wbWe} <= 3'h0;
        wbAdr <= ~a;
        wbDatW <= ~d;
    endtask
    task automatic wbWrite(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, a, d, q);
    endtask
    task automatic wbRead(input logic [31:0] a, output logic [31:0] q);
        access(1'b0, a, 32'h00000000, q);
    endtask
endmodule
`default_nettype wire

// [test/wide_memory_ecc_error_log_tb.sv]
// Self-checking bench for ECC correction, error log, panel controls and transfer modes.
`timescale 1ns/1ps
`default_nettype none
module wide_memory_ecc_error_log_tb;
    import ecc_log_pkg::*;
    logic mclk, rst_n, logClear, logBegin, logExamine, wbAck, wbWe, wbCyc, wbStb;
    logic logFullLamp, errorLamp, readyLamp, displayOn;
    logic [31:0] wbAdr, wbDatW, wbDatR, s;
    logic [3:0] wbSel, arrayBoardSelect;
    logic [CODE_W-1:0] faultInjectLo, faultInjectHi;
    logic [79:0] lowerHalfDataBus, upperHalfDataBus;
    logic [19:0] arrayAddressLines;
    logEntry_s displayEntry;
    logic [23:0] curAddr;
    logic [127:0] pat, nw;
    int failures = 0, compares = 0, cyc = 0, n;
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    host_board_model u_host (.mclk(mclk), .wbAck(wbAck), .wbDatR(wbDatR), .wbAdr(wbAdr), .wbDatW(wbDatW),
        .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb));
    wide_memory_ecc_error_log #(.MEM_AW(6)) u_dut (.mclk(mclk), .rst_n(rst_n), .wb_adr_i(wbAdr),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_sel_i(wbSel), .wb_we_i(wbWe), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_ack_o(wbAck), .logClear(logClear), .logBegin(logBegin), .logExamine(logExamine),
        .faultInjectLo(faultInjectLo), .faultInjectHi(faultInjectHi), .lowerHalfDataBus(lowerHalfDataBus),
        .upperHalfDataBus(upperHalfDataBus), .arrayBoardSelect(arrayBoardSelect),
        .arrayAddressLines(arrayAddressLines), .logFullLamp(logFullLamp), .errorLamp(errorLamp),
        .readyLamp(readyLamp), .displayOn(displayOn), .displayEntry(displayEntry));
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // The whole run needs little more than a thousand cycles; the ceiling leaves wide margin.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] ra(input logic [4:0] o);
        return {27'h0000000, o};
    endfunction
    task automatic xfer(input logic [2:0] mode, input logic [15:0] sel, input logic mAll, input logic [127:0] d);
        u_host.wbWrite(ra(WB_REG_ADDR), {8'h00, curAddr});
        u_host.wbWrite(ra(WB_REG_MODE), {sel, 12'h000, mAll, mode});
        for (int i = 3; i >= 0; i--) u_host.wbWrite(ra(WB_REG_WDAT), d[i*32+:32]);
        u_host.wbWrite(ra(WB_REG_CTRL), 32'h00000001);
        n = 0;
        do begin
            u_host.wbRead(ra(WB_REG_STAT), s);
            n++;
        end while ((s[3] !== 1'b1 || s[4] !== 1'b0) && n < 50);
        check(n < 50, 1'b1);
    endtask
    task automatic readBack(input logic [127:0] e);
        xfer(MODE_WW_READ, 16'h0000, 1'b0, 128'h0);
        check({upperHalfDataBus[63:0], lowerHalfDataBus[63:0]}, e);
        check({upperHalfDataBus[79:72], lowerHalfDataBus[79:72]}, 16'h0000);
    endtask
    task automatic tap(input logic clr);
        if (clr) logClear <= 1'b1;
        else logBegin <= 1'b1;
        @(posedge mclk);
        {logClear, logBegin} <= 2'h0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic exam(input logic w);
        logExamine <= 1'b1;
        repeat (3) @(posedge mclk);
        check(displayOn, 1'b1);
        check({displayEntry.board, displayEntry.row, displayEntry.word}, {curAddr[23:19], w});
        check(displayEntry.bitPos < 7'h50, 1'b1);
        logExamine <= 1'b0;
        repeat (3) @(posedge mclk);
        check(displayOn, 1'b0);
    endtask
    initial begin
        {rst_n, logClear, logBegin, logExamine} = 4'h0;
        faultInjectLo = 72'h0;
        faultInjectHi = 72'h0;
        repeat (12) @(posedge mclk);
        check(readyLamp, 1'b0);
        rst_n <= 1'b1;
        n = 0;
        while (readyLamp !== 1'b1 && n < 300) begin
            @(posedge mclk);
            n++;
        end
        check(n >= PWRUP_CYCLES && n < 300, 1'b1);
        check(errorLamp, 1'b0);
        u_host.wbRead(32'h00000040, s);
        check(s, 32'h00000000);
        curAddr = 24'hB80005;
        pat = 128'h0123456789ABCDEFFEDCBA9876543210;
        xfer(MODE_WW_WRITE, 16'h0000, 1'b0, pat);
        check({arrayBoardSelect, arrayAddressLines}, curAddr);
        readBack(pat);
        u_host.wbRead(ra(WB_REG_RDAT), s);
        check(s, pat[31:0]);
        faultInjectLo <= 72'h000000000000000200;
        readBack(pat);
        check(errorLamp, 1'b1);
        faultInjectLo <= 72'h0;
        tap(1'b0);
        exam(1'b0);
        u_host.wbRead(ra(WB_REG_CNT), s);
        check(s[8:0], 9'h021);
        tap(1'b0);
        u_host.wbRead(ra(WB_REG_CNT), s);
        check(s[8:0], 9'h001);
        faultInjectLo <= 72'h000000010000000000;
        faultInjectHi <= 72'h000000000000000008;
        readBack(pat);
        faultInjectLo <= 72'h0;
        faultInjectHi <= 72'h300;
        tap(1'b1);
        check({errorLamp, logFullLamp}, 2'h0);
        xfer(MODE_WW_READ, 16'h0000, 1'b0, 128'h0);
        u_host.wbRead(ra(WB_REG_STAT), s);
        check(s[9], 1'b1);
        faultInjectHi <= 72'h0;
        tap(1'b0);
        exam(1'b1);
        faultInjectLo <= 72'h000000000000000200;
        for (int i = 0; i < 20; i++) xfer(MODE_WW_READ, 16'h0000, 1'b0, 128'h0);
        check({logFullLamp, errorLamp}, 2'h3);
        u_host.wbRead(ra(WB_REG_CNT), s);
        check(s[4:0], 5'h10);
        faultInjectLo <= 72'h0;
        tap(1'b1);
        check({errorLamp, logFullLamp}, 2'h0);
        curAddr = 24'h100002;
        nw = {16{8'hA5}};
        xfer(MODE_WW_WRITE, 16'h0000, 1'b0, pat);
        xfer(MODE_BYTE_WRITE, 16'hFFFF, 1'b0, nw);
        readBack({pat[127:72], nw[71:0]});
        xfer(MODE_RMW_BYTE, 16'h8001, 1'b0, 128'h0);
        readBack({8'h00, pat[119:72], nw[71:8], 8'h00});
        xfer(MODE_RMW_WORD, 16'h0000, 1'b0, pat);
        readBack({8'h00, pat[119:72], nw[71:8], 8'h00});
        xfer(MODE_RMW_WORD, 16'h0000, 1'b1, pat);
        readBack(pat);
        tally_and_finish();
    end
endmodule
`default_nettype wire
